//--- rtl/ipc_pkg.sv
package ipc_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_SRC_DEF = 64;   // Default number of user sources
    localparam int SRC_PER_WORD = 16;  // Flag / enable bits per word
    localparam int PRIO_PER_WORD = 4;  // Priority fields per word
    localparam int PRIO_W = 3;         // Priority field width
    localparam int PRIO_STRIDE = 4;    // Priority field stride
    localparam int VEC_W = 7;          // Vector number width
    localparam int LVL_W = 4;          // CPU level width
    localparam int EXT_PINS = 5;       // External request pins
    localparam int ADDR_W = 12;        // APB address width
    // Source index fed by each external pin
    localparam int EXT_SRC_IDX [EXT_PINS] = '{0, 20, 29, 53, 60};
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] FLAG_BASE = 12'h000;
    localparam logic [11:0] ENABLE_BASE = 12'h040;
    localparam logic [11:0] PRIO_BASE = 12'h080;
    localparam logic [11:0] STATUS_OFS = 12'h100;
    localparam logic [11:0] CORE_OFS = 12'h104;
    localparam logic [11:0] CTL1_OFS = 12'h108;
    localparam logic [11:0] CTL2_OFS = 12'h10c;
    localparam logic [11:0] TAKEN_OFS = 12'h110;
    // ------------------------------------------------------------
    // Field positions and masks
    // ------------------------------------------------------------
    localparam int LEVEL_LSB = 5;      // Level field in status word
    localparam int EXT_BIT = 3;        // Extension bit in core control
    localparam int NEST_BIT = 15;      // Nesting disable in control one
    localparam int TRAP_EN_LSB = 8;    // Trap enables in control one
    localparam int ALT_BIT = 15;       // Table select in control two
    localparam int TDIS_BIT = 14;      // Timed disable in control two
    localparam int TAKEN_LVL_LSB = 8;  // New level in taken status
    localparam logic [15:0] CTL1_FLAG_MASK = 16'h78fe;
    localparam logic [15:0] CTL1_RW_MASK = 16'h8700;
    localparam logic [15:0] CTL2_RW_MASK = 16'h801f;
    // ------------------------------------------------------------
    // Reset values and levels
    // ------------------------------------------------------------
    localparam logic [3:0] LEVEL_RST = 4'h0;
    localparam logic [3:0] NEST_LEVEL = 4'h7;
    localparam logic [15:0] CTL_RST = 16'h0000;
endpackage : ipc_pkg

//--- rtl/ipc_top.sv
// Behaviour
// - One sticky request flag per source
// - Per-source enable gates flag into arbitration
// - Software priority field, seven levels, zero disables
// - Latch vector and new level when taken
// - Software writes level field, used for masking
// - Extension bit is read-only to software
// - Bit positions follow source number order
// - Equal priority, lower source number wins
// - Level is extension bit over 3-bit field
// - Extension bit reads 1 above level 7
// - Level field read-only while nesting disabled
// - Control one bit 15 disables nesting
// - Control one holds sticky trap cause flags
// - Control two bit 15 selects alternate table
// - Control two bits 4-0 pin edge polarity
// - Unimplemented bits ignore writes, read zero
// - Present only priority above CPU level
// - Nesting disabled forces level 7 on entry
// - Timed disable status bit, blocks user requests
module ipc_top
    import ipc_pkg::*;
#(
    parameter int NUM_SRC = NUM_SRC_DEF
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Event sources
    input wire logic [NUM_SRC-1:0] periphEvent,
    input wire logic [EXT_PINS-1:0] extPin,
    input wire logic [15:0] trapEvent,
    input wire logic timedDisable,
    // Core handshake
    input wire logic intTaken,
    input wire logic levelLoad,
    input wire logic [LVL_W-1:0] levelLoadValue,
    output logic irqReq,
    output logic [VEC_W-1:0] irqVector,
    output logic [LVL_W-1:0] irqLevel,
    // Control outputs
    output logic altTableSelect,
    output logic [2:0] trapEnable,
    output logic nestingDisable,
    output logic [LVL_W-1:0] cpuLevel
);
    // ------------------------------------------------------------
    // Derived sizes and helpers
    // ------------------------------------------------------------
    localparam int NFW = NUM_SRC / SRC_PER_WORD;   // Flag words
    localparam int NPW = NUM_SRC / PRIO_PER_WORD;  // Priority words

    // Word address falls inside a register bank
    function automatic logic inBank(input logic [9:0] w,
                                    input logic [11:0] base, input int n);
        return (w >= base[11:2]) && (w < base[11:2] + 10'(n));
    endfunction : inBank

    // External pin feeding a source, or -1
    function automatic int pinOf(input int src);
        int p;
        p = -1;
        for (int k = 0; k < EXT_PINS; k++) begin
            if (EXT_SRC_IDX[k] == src) begin
                p = k;
            end
        end
        return p;
    endfunction : pinOf

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [NUM_SRC-1:0] flag_ff;            // Request flags
    logic [NUM_SRC-1:0] enable_ff;          // Source enables
    logic [PRIO_W*NUM_SRC-1:0] prio_ff;     // Packed priorities
    logic [LVL_W-1:0] cpuLevel_ff;          // Current CPU level
    logic [15:0] ctl1_ff;                   // Control one
    logic [15:0] ctl2_ff;                   // Control two, stored bits
    logic [VEC_W-1:0] takenVec_ff;          // Latched vector
    logic [LVL_W-1:0] takenLvl_ff;          // Latched new level
    logic irqReq_ff;                        // Request to core
    logic [VEC_W-1:0] irqVec_ff;            // Presented vector
    logic [LVL_W-1:0] irqLvl_ff;            // Presented level
    logic [EXT_PINS-1:0] extPrev_ff;        // Previous pin levels
    logic [31:0] rdData_ff;                 // Read data

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire [9:0] wordAddr = paddr[11:2];
    wire apbWr = psel & penable & pwrite;   // Zero-wait access phase
    wire apbSetup = psel & ~penable;        // Read data capture
    wire flagHit = inBank(wordAddr, FLAG_BASE, NFW);
    wire enHit = inBank(wordAddr, ENABLE_BASE, NFW);
    wire prioHit = inBank(wordAddr, PRIO_BASE, NPW);
    wire statusHit = inBank(wordAddr, STATUS_OFS, 1);
    wire coreHit = inBank(wordAddr, CORE_OFS, 1);
    wire ctl1Hit = inBank(wordAddr, CTL1_OFS, 1);
    wire ctl2Hit = inBank(wordAddr, CTL2_OFS, 1);
    wire takenHit = inBank(wordAddr, TAKEN_OFS, 1);
    wire anyHit = flagHit | enHit | prioHit | statusHit | coreHit |
                  ctl1Hit | ctl2Hit | takenHit;
    wire [9:0] flagIdx = wordAddr - FLAG_BASE[11:2];
    wire [9:0] enIdx = wordAddr - ENABLE_BASE[11:2];
    wire [9:0] prioIdx = wordAddr - PRIO_BASE[11:2];
    wire statusWr = apbWr & statusHit;
    wire ctl1Wr = apbWr & ctl1Hit;
    wire ctl2Wr = apbWr & ctl2Hit;

    // ------------------------------------------------------------
    // External pin edge detection
    // ------------------------------------------------------------
    logic [EXT_PINS-1:0] extEdge;           // One-cycle edge pulses
    assign extEdge = (ctl2_ff[EXT_PINS-1:0] & extPrev_ff & ~extPin) |
                     (~ctl2_ff[EXT_PINS-1:0] & ~extPrev_ff & extPin);

    // ------------------------------------------------------------
    // Per-source flag, enable and priority next values
    // ------------------------------------------------------------
    logic [NUM_SRC-1:0] srcSet;             // Set events per source
    logic [NUM_SRC-1:0] nxt_flag;
    logic [NUM_SRC-1:0] nxt_enable;
    logic [PRIO_W*NUM_SRC-1:0] nxt_prio;
    logic [NUM_SRC-1:0] pend;               // Enabled, nonzero, flagged
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
            localparam int FW = gi / SRC_PER_WORD;
            localparam int FB = gi % SRC_PER_WORD;
            localparam int PW = gi / PRIO_PER_WORD;
            localparam int PB = (gi % PRIO_PER_WORD) * PRIO_STRIDE;
            localparam int PIN = pinOf(gi);
            wire flagWr = apbWr & flagHit & (flagIdx == 10'(FW));
            wire enWr = apbWr & enHit & (enIdx == 10'(FW));
            wire prWr = apbWr & prioHit & (prioIdx == 10'(PW));
            wire [PRIO_W-1:0] prio = prio_ff[gi*PRIO_W +: PRIO_W];
            if (PIN >= 0) begin : g_pin
                assign srcSet[gi] = periphEvent[gi] | extEdge[PIN];
            end else begin : g_nopin
                assign srcSet[gi] = periphEvent[gi];
            end
            assign nxt_flag[gi] = (flagWr ? pwdata[FB] : flag_ff[gi]) | srcSet[gi];
            assign nxt_enable[gi] = enWr ? pwdata[FB] : enable_ff[gi];
            assign nxt_prio[gi*PRIO_W +: PRIO_W] = prWr ? pwdata[PB +: PRIO_W] : prio;
            assign pend[gi] = flag_ff[gi] & enable_ff[gi] & (prio != '0);
        end
    endgenerate

    // ------------------------------------------------------------
    // Arbitration: highest priority, lowest index on ties
    // ------------------------------------------------------------
    logic [PRIO_W-1:0] bestPrio;
    logic [VEC_W-1:0] bestVec;
    logic bestValid;
    always_comb begin
        bestPrio = '0;
        bestVec = '0;
        bestValid = 1'b0;
        for (int k = NUM_SRC - 1; k >= 0; k--) begin
            if (pend[k] && (prio_ff[k*PRIO_W +: PRIO_W] >= bestPrio)) begin
                bestPrio = prio_ff[k*PRIO_W +: PRIO_W];
                bestVec = VEC_W'(k);
                bestValid = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Presentation and level control
    // ------------------------------------------------------------
    wire [LVL_W-1:0] bestLvl = {1'b0, bestPrio};
    wire nestDis = ctl1_ff[NEST_BIT];
    wire takeNow = intTaken & irqReq_ff;    // Core accepts request
    wire present = bestValid & (bestLvl > cpuLevel_ff) & ~timedDisable;
    wire nxt_irqReq = present & ~takeNow;
    logic [LVL_W-1:0] nxt_level;
    assign nxt_level = levelLoad ? levelLoadValue :
                       takeNow ? (nestDis ? NEST_LEVEL : irqLvl_ff) :
                       (statusWr & ~nestDis) ?
                       {cpuLevel_ff[3], pwdata[LEVEL_LSB +: 3]} : cpuLevel_ff;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    wire [15:0] ctl1Base = ctl1Wr ? pwdata[15:0] : ctl1_ff;
    wire [15:0] nxt_ctl1 = (ctl1Base & (CTL1_RW_MASK | CTL1_FLAG_MASK)) |
                           (trapEvent & CTL1_FLAG_MASK);
    wire [15:0] nxt_ctl2 = ctl2Wr ? (pwdata[15:0] & CTL2_RW_MASK) : ctl2_ff;

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    logic [15:0] prioWord;
    genvar gj;
    generate
        for (gj = 0; gj < PRIO_PER_WORD; gj++) begin : g_prd
            assign prioWord[gj*PRIO_STRIDE +: PRIO_STRIDE] =
                {1'b0, prio_ff[(int'(prioIdx)*PRIO_PER_WORD+gj)*PRIO_W +: PRIO_W]};
        end
    endgenerate
    wire [15:0] flagWord = flag_ff[int'(flagIdx)*SRC_PER_WORD +: SRC_PER_WORD];
    wire [15:0] enWord = enable_ff[int'(enIdx)*SRC_PER_WORD +: SRC_PER_WORD];
    wire [15:0] statusWord = {8'h00, cpuLevel_ff[2:0], 5'h00};
    wire [15:0] coreWord = {12'h000, cpuLevel_ff[3], 3'h0};
    wire [15:0] ctl2Word = ctl2_ff | {1'b0, timedDisable, 14'h0000};
    wire [15:0] takenWord = {4'h0, takenLvl_ff, 1'b0, takenVec_ff};
    wire [15:0] rdMux = flagHit ? flagWord :
                        enHit ? enWord :
                        prioHit ? prioWord :
                        statusHit ? statusWord :
                        coreHit ? coreWord :
                        ctl1Hit ? ctl1_ff :
                        ctl2Hit ? ctl2Word :
                        takenHit ? takenWord : 16'h0000;

    // ------------------------------------------------------------
    // Sequential logic
    // ------------------------------------------------------------
    // Source state
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            flag_ff <= '0;
            enable_ff <= '0;
            prio_ff <= '0;
            extPrev_ff <= '0;
        end else begin
            flag_ff <= nxt_flag;
            enable_ff <= nxt_enable;
            prio_ff <= nxt_prio;
            extPrev_ff <= extPin;
        end
    end

    // Level and control words
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cpuLevel_ff <= LEVEL_RST;
            ctl1_ff <= CTL_RST;
            ctl2_ff <= CTL_RST;
        end else begin
            cpuLevel_ff <= nxt_level;
            ctl1_ff <= nxt_ctl1;
            ctl2_ff <= nxt_ctl2;
        end
    end

    // Request to core and taken latch
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            irqReq_ff <= 1'b0;
            irqVec_ff <= '0;
            irqLvl_ff <= '0;
            takenVec_ff <= '0;
            takenLvl_ff <= '0;
        end else begin
            irqReq_ff <= nxt_irqReq;
            irqVec_ff <= bestVec;
            irqLvl_ff <= bestLvl;
            if (takeNow) begin
                takenVec_ff <= irqVec_ff;
                takenLvl_ff <= irqLvl_ff;
            end
        end
    end

    // Read data, captured in the setup phase
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rdData_ff <= '0;
        end else if (apbSetup) begin
            rdData_ff <= {16'h0000, rdMux};
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata = rdData_ff;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~anyHit;
    assign irqReq = irqReq_ff;
    assign irqVector = irqVec_ff;
    assign irqLevel = irqLvl_ff;
    assign altTableSelect = ctl2_ff[ALT_BIT];
    assign trapEnable = ctl1_ff[TRAP_EN_LSB +: 3];
    assign nestingDisable = nestDis;
    assign cpuLevel = cpuLevel_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_flag_set_sticky: assert property (srcSet[0] |=> flag_ff[0])
        else $error("source 0 event lost");
    a_flag_hold_clear: assert property (flag_ff[0] && !srcSet[0] &&
        !(apbWr && flagHit && flagIdx == 10'h000) |=> flag_ff[0])
        else $error("flag cleared without write");
    a_req_needs_enable: assert property (irqReq_ff |->
        $past(|(flag_ff & enable_ff)))
        else $error("request without enabled flag");
    a_req_above_level: assert property (irqReq_ff |->
        ($past(bestLvl) > $past(cpuLevel_ff)) && ($past(bestLvl) != 4'h0))
        else $error("request not above CPU level");
    a_taken_latch: assert property (takeNow |=>
        (takenVec_ff == $past(irqVec_ff)) && (takenLvl_ff == $past(irqLvl_ff)))
        else $error("taken status not latched");
    a_nest_force7: assert property (takeNow && nestDis && !levelLoad |=>
        cpuLevel_ff == 4'h7)
        else $error("nesting off entry not level 7");
    a_nest_field_ro: assert property (statusWr && nestDis && !levelLoad &&
        !takeNow |=> $stable(cpuLevel_ff))
        else $error("level field changed while read-only");
    a_sw_level_write: assert property (statusWr && !nestDis && !levelLoad &&
        !takeNow |=> cpuLevel_ff[2:0] == $past(pwdata[7:5]))
        else $error("software level write lost");
    a_timed_block: assert property (timedDisable |=> !irqReq_ff)
        else $error("request during timed disable");
    a_ext_rise: assert property ($rose(extPin[0]) && !ctl2_ff[0] |=>
        flag_ff[EXT_SRC_IDX[0]])
        else $error("pin 0 rising edge missed");
    a_upper_zero: assert property (prdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    a_trap_set: assert property (trapEvent[2] |=> ctl1_ff[2])
        else $error("stack trap flag not set");
endmodule : ipc_top

//--- testbench/ipc_core_model.sv
// Core side: accepts presented requests after a random delay, loads levels
module ipc_core_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Request from the controller
    input wire logic irqReq,
    // Core answers
    output logic intTaken,
    output logic levelLoad,
    output logic [3:0] levelLoadValue
);
    timeunit 1ns;
    timeprecision 1ps;
    int takeCount = 0; // Requests accepted so far
    int waitCyc = 0;   // Delay before the next accept
    // --------------------------------------------------------------
    // Accept logic
    // --------------------------------------------------------------
    // accept presented request
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            intTaken <= 1'b0;
            waitCyc <= 0;
        end else if (irqReq && !intTaken && waitCyc == 0) begin
            intTaken <= 1'b1;
            takeCount <= takeCount + 1;
            waitCyc <= $urandom_range(0, 3);
        end else begin
            intTaken <= 1'b0;
            waitCyc <= (irqReq && waitCyc > 0) ? waitCyc - 1 : waitCyc;
        end
    end
    initial begin
        levelLoad = 1'b0;
        levelLoadValue = 4'h0;
    end
    task doReturn(input logic [3:0] v);
        @(posedge clk_sys);
        levelLoad <= 1'b1;
        levelLoadValue <= v;
        @(posedge clk_sys);
        levelLoad <= 1'b0;
    endtask : doReturn
endmodule : ipc_core_model

//--- testbench/ipc_top_test.sv
`define CHK(a, e) begin checksDone++; if ((a) !== (e)) begin errCount++; \
    $display("[FAIL] %0t got=%h exp=%h", $time, (a), (e)); end end
module ipc_top_test import ipc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------------------------------------------------
    // Signals
    // --------------------------------------------------------------
    logic clk_sys = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic timedDisable = 1'b0, pready, pslverr, irqReq, intTaken, levelLoad;
    logic altTableSelect, nestingDisable;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, fw;
    logic [63:0] periphEvent = '0;
    logic [4:0] extPin = 5'h00;
    logic [15:0] trapEvent = 16'h0000;
    logic [6:0] irqVector, s1, s2;
    logic [3:0] irqLevel, cpuLevel, levelLoadValue;
    logic [2:0] trapEnable, p;
    logic [2:0] prio [64];        // Priority per source
    logic [32:0] expQ [$];        // Expected {pslverr, prdata}
    logic [32:0] expV;
    logic [11:0] rstRegs [6] = '{STATUS_OFS, CORE_OFS, CTL1_OFS, CTL2_OFS, TAKEN_OFS, 12'h000};
    int errCount = 0, checksDone = 0, nt = 0;
    always #4 clk_sys = ~clk_sys;
    ipc_top i_ipc_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .periphEvent(periphEvent), .extPin(extPin), .trapEvent(trapEvent),
        .timedDisable(timedDisable), .intTaken(intTaken), .levelLoad(levelLoad),
        .levelLoadValue(levelLoadValue), .irqReq(irqReq), .irqVector(irqVector),
        .irqLevel(irqLevel), .altTableSelect(altTableSelect), .trapEnable(trapEnable),
        .nestingDisable(nestingDisable), .cpuLevel(cpuLevel));
    ipc_core_model i_ipc_core_model (.clk_sys(clk_sys), .sys_rst(sys_rst), .irqReq(irqReq),
        .intTaken(intTaken), .levelLoad(levelLoad), .levelLoadValue(levelLoadValue));
    // Oldest note is compared when a read completes
    always @(posedge clk_sys) begin
        if (psel && penable && pready && !pwrite) begin
            expV = expQ.pop_front();
            `CHK({pslverr, prdata}, expV)
        end
    end
    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    task finishTest;
        $display("checks=%0d mismatches=%0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finishTest
    // One APB transfer, held until pready is seen
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
        int n;
        if (!wr) expQ.push_back(e);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            errCount++;
            finishTest();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask : wr
    task rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e});
    endtask : rd
    function automatic logic [11:0] fa(input logic [6:0] s);
        return FLAG_BASE + {6'h0, s[5:4], 2'h0};
    endfunction : fa
    // Writes every priority word from the prio table
    task setPrio;
        logic [31:0] v;
        for (int w = 0; w < 16; w++) begin
            v = 32'h0;
            for (int j = 0; j < 4; j++) v[4*j +: 3] = prio[4*w+j];
            wr(PRIO_BASE + 12'(4 * w), v);
        end
    endtask : setPrio
    task clearFlags;
        for (int w = 0; w < 4; w++) wr(FLAG_BASE + 12'(4 * w), 32'h0);
    endtask : clearFlags
    task pulse(input logic [63:0] ev);
        @(posedge clk_sys);
        periphEvent <= ev;
        @(posedge clk_sys);
        periphEvent <= '0;
    endtask : pulse
    // Bounded wait for the next accepted request
    task waitTake;
        int k;
        nt++;
        k = 0;
        while (i_ipc_core_model.takeCount < nt && k < 100) begin
            @(posedge clk_sys);
            k++;
        end
        if (k >= 100) begin
            errCount++;
            finishTest();
        end
        repeat (2) @(posedge clk_sys);
    endtask : waitTake
    // --------------------------------------------------------------
    // Sequence
    // --------------------------------------------------------------
    initial begin
        void'($urandom(24));
        prio = '{default: 3'h0};
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        for (int i = 0; i < 6; i++) rd(rstRegs[i], 32'h0);
        apb(1'b0, 12'h200, 32'h0, {1'b1, 32'h0});
        $display("reset values done");
        wr(CTL1_OFS, 32'hffff);
        rd(CTL1_OFS, 32'hfffe);
        `CHK({nestingDisable, trapEnable}, 4'hf)
        wr(CTL1_OFS, 32'h0);
        @(posedge clk_sys) trapEvent <= 16'hffff;
        @(posedge clk_sys) trapEvent <= 16'h0000;
        rd(CTL1_OFS, {16'h0, CTL1_FLAG_MASK});
        wr(CTL1_OFS, 32'h0);
        wr(CTL2_OFS, 32'hffff);
        rd(CTL2_OFS, 32'h801f);
        `CHK(altTableSelect, 1'b1)
        wr(CTL2_OFS, 32'h0);
        wr(CORE_OFS, 32'hffff);
        rd(CORE_OFS, 32'h0);
        $display("control registers done");
        for (int w = 0; w < 4; w++) wr(ENABLE_BASE + 12'(4 * w), 32'hffff);
        for (int i = 0; i < 3; i++) begin
            s1 = 7'($urandom_range(1, 40));
            s2 = s1 + 7'($urandom_range(1, 8));
            p = 3'($urandom_range(1, 7));
            prio = '{default: 3'h0};
            prio[s1] = p;
            prio[s2] = p;
            setPrio();
            pulse((64'h1 << s1) | (64'h1 << s2));
            waitTake();
            rd(TAKEN_OFS, {20'h0, 1'b0, p, 1'b0, s1});
            `CHK(cpuLevel, {1'b0, p})
            fw = 32'h1 << s1[3:0];
            if (fa(s1) == fa(s2)) fw = fw | (32'h1 << s2[3:0]);
            rd(fa(s1), fw);
            wr(fa(s1), fw & ~(32'h1 << s1[3:0]));
            i_ipc_core_model.doReturn(4'h0);
            waitTake();
            rd(TAKEN_OFS, {20'h0, 1'b0, p, 1'b0, s2});
            clearFlags();
            i_ipc_core_model.doReturn(4'h0);
        end
        $display("arbitration done");
        prio = '{default: 3'h0};
        prio[3] = 3'h5;
        prio[5] = 3'h7;
        setPrio();
        wr(ENABLE_BASE, 32'hffdf);
        wr(STATUS_OFS, 32'h00a0);
        rd(STATUS_OFS, 32'h00a0);
        pulse(64'h38);
        repeat (12) @(posedge clk_sys);
        `CHK(i_ipc_core_model.takeCount, nt)
        timedDisable <= 1'b1;
        wr(ENABLE_BASE, 32'hffff);
        repeat (12) @(posedge clk_sys);
        `CHK(i_ipc_core_model.takeCount, nt)
        `CHK(irqReq, 1'b0)
        `CHK({irqVector, irqLevel}, {7'h05, 4'h7})
        rd(CTL2_OFS, 32'h4000);
        timedDisable <= 1'b0;
        waitTake();
        rd(TAKEN_OFS, 32'h0705);
        clearFlags();
        i_ipc_core_model.doReturn(4'h0);
        $display("masking done");
        wr(CTL1_OFS, 32'h8000);
        prio = '{default: 3'h0};
        prio[6] = 3'h2;
        setPrio();
        pulse(64'h40);
        waitTake();
        `CHK(cpuLevel, NEST_LEVEL)
        rd(TAKEN_OFS, 32'h0206);
        wr(STATUS_OFS, 32'h0);
        rd(STATUS_OFS, 32'h00e0);
        i_ipc_core_model.doReturn(4'h9);
        rd(CORE_OFS, 32'h8);
        rd(STATUS_OFS, 32'h0020);
        wr(CORE_OFS, 32'h0);
        rd(CORE_OFS, 32'h8);
        clearFlags();
        i_ipc_core_model.doReturn(4'h0);
        rd(CORE_OFS, 32'h0);
        wr(CTL1_OFS, 32'h0);
        $display("nesting done");
        prio = '{default: 3'h0};
        setPrio();
        wr(CTL2_OFS, 32'h2);
        @(posedge clk_sys) extPin <= 5'h03;
        repeat (3) @(posedge clk_sys);
        rd(FLAG_BASE, 32'h1);
        rd(FLAG_BASE + 12'h004, 32'h0);
        @(posedge clk_sys) extPin <= 5'h00;
        repeat (3) @(posedge clk_sys);
        rd(FLAG_BASE + 12'h004, 32'h10);
        $display("edge polarity done");
        finishTest();
    end
endmodule : ipc_top_test
